// File: rtl/ssd_sysref_ctrl.v
// Purpose: SYSREF source select, divider, delay, burst and feedback mux control
// Assumes: core_clk is the distribution clock; serial port sampled on it
// Notes:   Serial clock must be well below core_clk/4 for edge detection
`timescale 1ns/1ps
`include "ssd_map.vh"
module ssd_sysref_ctrl (
    input  wire core_clk,
    input  wire rst,
    input  wire spi_sck,
    input  wire spi_cs_n,
    input  wire spi_sdi,
    output reg  spi_sdo,
    output wire spi_sdo_oe,
    input  wire sync_in,
    input  wire reference_input_zero,
    input  wire device_clock_output_six,
    input  wire device_clock_output_eight,
    input  wire external_feedback_in,
    output reg  sysref_out,
    output reg  feedback_clk_out,
    output wire loop_two_ndiv_input_select,
    output wire loop_one_ndelay_input_select,
    output wire feedback_select_power_on,
    output wire sysref_burst_busy
);
    // Pin synchronisers; frame select enters inverted so reset reads as deselected
    wire [7:0] pins_s;
    ssd_sync2 #(.WIDTH(8)) ssd_sync2_i (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({spi_sck, ~spi_cs_n, spi_sdi, sync_in, reference_input_zero,
                    device_clock_output_six, device_clock_output_eight,
                    external_feedback_in}),
        .sync_out (pins_s)
    );
    wire sck_s  = pins_s[7];
    wire csn_s  = ~pins_s[6];                  // No false frame end after reset
    wire sdi_s  = pins_s[5];
    wire sync_s = pins_s[4];
    wire ref0_s = pins_s[3];
    wire dc6_s  = pins_s[2];
    wire dc8_s  = pins_s[1];
    wire ext_s  = pins_s[0];

    // Register file
    reg [7:0] src_reg, div_hi_reg, div_lo_reg, dly_hi_reg, dly_lo_reg;
    reg [7:0] burst_reg, fb_reg, pwr_reg;

    // Serial port state
    reg        sck_d_reg;
    reg        csn_d_reg;
    reg [4:0]  bit_cnt_reg;
    reg [23:0] shift_reg;
    reg [7:0]  rd_shift_reg;
    reg        rd_mode_reg;
    wire       sck_rise = sck_s & ~sck_d_reg;
    wire       sck_fall = ~sck_s & sck_d_reg;
    wire       cs_end   = csn_s & ~csn_d_reg;
    wire [12:0] hdr_addr = shift_reg[12:0];
    wire       wr_go    = cs_end & (bit_cnt_reg == `SSD_FRAME_BITS) & ~shift_reg[23];
    wire [12:0] wr_addr = shift_reg[20:8];
    wire [7:0] wr_data  = shift_reg[7:0];

    assign spi_sdo_oe = rd_mode_reg & ~csn_s;

    // Readback mux, reserved bits forced to zero
    reg [7:0] rd_data;
    always @* begin
        case (hdr_addr)
            `SSD_ADDR_SRC:    rd_data = {5'h00, src_reg[2:0]};
            `SSD_ADDR_DIV_HI: rd_data = {3'h0, div_hi_reg[4:0]};
            `SSD_ADDR_DIV_LO: rd_data = div_lo_reg;
            `SSD_ADDR_DLY_HI: rd_data = {3'h0, dly_hi_reg[4:0]};
            `SSD_ADDR_DLY_LO: rd_data = dly_lo_reg;
            `SSD_ADDR_BURST:  rd_data = {6'h00, burst_reg[1:0]};
            `SSD_ADDR_FB:     rd_data = {3'h0, fb_reg[4:0]};
            `SSD_ADDR_PWR:    rd_data = {5'h00, pwr_reg[2:0]};
            default:          rd_data = 8'h00;
        endcase
    end

    // Frame shifter: bits enter on rising sck, read data leaves on falling sck
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sck_d_reg    <= 1'b0;
            csn_d_reg    <= 1'b1;
            bit_cnt_reg  <= 5'h00;
            shift_reg    <= 24'h000000;
            rd_shift_reg <= 8'h00;
            rd_mode_reg  <= 1'b0;
            spi_sdo      <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
            csn_d_reg <= csn_s;
            if (csn_s) begin
                bit_cnt_reg <= 5'h00;
                rd_mode_reg <= 1'b0;
            end else if (sck_rise && bit_cnt_reg != `SSD_FRAME_BITS) begin
                shift_reg   <= {shift_reg[22:0], sdi_s};
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end else if (sck_fall && bit_cnt_reg == `SSD_HDR_BITS) begin
                rd_mode_reg  <= shift_reg[15];
                rd_shift_reg <= {rd_data[6:0], 1'b0};
                spi_sdo      <= rd_data[7];
            end else if (sck_fall && rd_mode_reg) begin
                spi_sdo      <= rd_shift_reg[7];
                rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
            end
        end
    end

    // Register writes at end of a complete write frame
    wire burst_wr = wr_go & (wr_addr == `SSD_ADDR_BURST);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src_reg    <= `SSD_RST_SRC;
            div_hi_reg <= `SSD_RST_DIV_HI;
            div_lo_reg <= `SSD_RST_DIV_LO;
            dly_hi_reg <= `SSD_RST_DLY_HI;
            dly_lo_reg <= `SSD_RST_DLY_LO;
            burst_reg  <= `SSD_RST_BURST;
            fb_reg     <= `SSD_RST_FB;
            pwr_reg    <= `SSD_RST_PWR;
        end else if (wr_go) begin
            case (wr_addr)
                `SSD_ADDR_SRC:    src_reg    <= {5'h00, wr_data[2:0]};
                `SSD_ADDR_DIV_HI: div_hi_reg <= {3'h0, wr_data[4:0]};
                `SSD_ADDR_DIV_LO: div_lo_reg <= wr_data;
                `SSD_ADDR_DLY_HI: dly_hi_reg <= {3'h0, wr_data[4:0]};
                `SSD_ADDR_DLY_LO: dly_lo_reg <= wr_data;
                `SSD_ADDR_BURST:  burst_reg  <= {6'h00, wr_data[1:0]};
                `SSD_ADDR_FB:     fb_reg     <= {3'h0, wr_data[4:0]};
                `SSD_ADDR_PWR:    pwr_reg    <= {5'h00, wr_data[2:0]};
                default:          ;
            endcase
        end
    end

    wire [1:0]  source_sel  = src_reg[1:0];
    wire        direct_sel  = src_reg[`SSD_SRC_DIRECT_BIT];
    wire [12:0] divide_prog = {div_hi_reg[4:0], div_lo_reg};
    wire [12:0] delay_prog  = {dly_hi_reg[4:0], dly_lo_reg};
    wire        sysref_circuit_powerdown   = pwr_reg[`SSD_PWR_SYSREF_BIT];
    wire        plsr_pd     = pwr_reg[`SSD_PWR_PLSR_BIT];

    // Divider and delay; programmed values load only on a sync event
    reg         sync_d_reg;
    reg         recl_reg;
    reg  [12:0] div_act_reg;
    reg  [12:0] dly_cnt_reg;
    reg  [12:0] ph_cnt_reg;
    localparam [15:0] div_reset_full = {`SSD_RST_DIV_HI, `SSD_RST_DIV_LO};
    wire        sync_evt = sync_s & ~sync_d_reg;
    wire        dly_done = (dly_cnt_reg == 13'h0000);
    wire        per_end  = dly_done & (ph_cnt_reg == div_act_reg - 13'h0001);
    wire        div_out  = dly_done & (ph_cnt_reg < {1'b0, div_act_reg[12:1]});
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_d_reg  <= 1'b0;
            recl_reg    <= 1'b0;
            div_act_reg <= div_reset_full[12:0];
            dly_cnt_reg <= 13'h0000;
            ph_cnt_reg  <= 13'h0000;
        end else begin
            sync_d_reg <= sync_s;
            if (per_end) begin
                recl_reg <= sync_s;                    // Sync retimed to divider phase
            end
            if (sysref_circuit_powerdown) begin
                dly_cnt_reg <= 13'h0000;
                ph_cnt_reg  <= 13'h0000;
            end else if (sync_evt) begin
                div_act_reg <= divide_prog;
                dly_cnt_reg <= delay_prog;
                ph_cnt_reg  <= 13'h0000;
            end else if (!dly_done) begin
                dly_cnt_reg <= dly_cnt_reg - 13'h0001;
            end else if (per_end) begin
                ph_cnt_reg <= 13'h0000;
            end else begin
                ph_cnt_reg <= ph_cnt_reg + 13'h0001;
            end
        end
    end

    // Burst generator: launch waits for a period boundary to keep whole pulses
    reg        pend_reg;
    reg  [3:0] left_reg;
    wire       burst_ok = (source_sel == `SSD_SRC_BURST) & ~sysref_circuit_powerdown & ~plsr_pd;
    assign sysref_burst_busy = pend_reg | (left_reg != 4'h0);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
            left_reg <= 4'h0;
        end else if (!burst_ok) begin
            pend_reg <= 1'b0;
            left_reg <= 4'h0;
        end else if (burst_wr) begin
            pend_reg <= 1'b1;
        end else if (per_end) begin
            if (pend_reg) begin
                pend_reg <= 1'b0;
                left_reg <= 4'h1 << burst_reg[1:0];
            end else if (left_reg != 4'h0) begin
                left_reg <= left_reg - 4'h1;
            end
        end
    end

    // Output source selection
    reg src_mux;
    always @* begin
        case (source_sel)
            `SSD_SRC_SYNC:  src_mux = sync_s;
            `SSD_SRC_RECLK: src_mux = recl_reg;
            `SSD_SRC_BURST: src_mux = div_out & (left_reg != 4'h0);
            `SSD_SRC_CONT:  src_mux = div_out;
            default:        src_mux = 1'b0;
        endcase
    end

    // Feedback path controls
    assign loop_two_ndiv_input_select   = fb_reg[`SSD_FB_LOOP2_BIT];
    assign loop_one_ndelay_input_select = fb_reg[`SSD_FB_LOOP1_BIT];
    assign feedback_select_power_on     = fb_reg[`SSD_FB_EN_BIT];
    reg feedback_path_control;
    always @* begin
        case (fb_reg[`SSD_FB_SEL_HI:`SSD_FB_SEL_LO])
            2'h0:    feedback_path_control = dc6_s;
            2'h1:    feedback_path_control = dc8_s;
            2'h2:    feedback_path_control = div_out & ~sysref_circuit_powerdown;
            2'h3:    feedback_path_control = ext_s;
            default: feedback_path_control = 1'b0;
        endcase
    end

    // Registered outputs; power-down silences sysref whatever the source
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sysref_out       <= 1'b0;
            feedback_clk_out <= 1'b0;
        end else begin
            sysref_out       <= ~sysref_circuit_powerdown & (direct_sel ? ref0_s : src_mux);
            feedback_clk_out <= feedback_select_power_on & feedback_path_control;
        end
    end
endmodule // ssd_sysref_ctrl

// File: rtl/ssd_map.vh
// Purpose: Register map, field positions, resets and serial frame layout
// Assumes: Byte registers reached over the three-wire serial control port
// Notes:   What this block does is listed below
//
// What this block does
// - Bit 2 routes the sysref output from source mux (0) or reference input zero (1).
// - Bits 1:0 pick source: sync, re-clocked sync, burst, continuous.
// - 13-bit divide, high five bits then low byte; 8..8191 divide by value.
// - 13-bit digital delay, high five bits then low byte; 8..8191 delay.
// - Burst-length write launches pulses when burst source selected and powered.
// - Burst length code n gives two-to-the-n pulses; reset value 3.
// - Bit 4 feeds loop two N divider from prescaler (0) or feedback mux (1).
// - Bit 3 feeds loop one N delay from oscillator input (0) or feedback mux (1).
// - Bits 2:1 pick feedback: output six, output eight, divider, external.
// - Circuit power-down set stops divider and sysref output; reset value 1.
// - Burst generator power-down set blocks bursts; reset value 1.
`ifndef SSD_MAP_VH
`define SSD_MAP_VH

// Register addresses
`define SSD_ADDR_SRC        13'h139
`define SSD_ADDR_DIV_HI     13'h13a
`define SSD_ADDR_DIV_LO     13'h13b
`define SSD_ADDR_DLY_HI     13'h13c
`define SSD_ADDR_DLY_LO     13'h13d
`define SSD_ADDR_BURST      13'h13e
`define SSD_ADDR_FB         13'h13f
`define SSD_ADDR_PWR        13'h140

// Reset values
`define SSD_RST_SRC         8'h00
`define SSD_RST_DIV_HI      8'h0c
`define SSD_RST_DIV_LO      8'h00
`define SSD_RST_DLY_HI      8'h00
`define SSD_RST_DLY_LO      8'h08
`define SSD_RST_BURST       8'h03
`define SSD_RST_FB          8'h00
`define SSD_RST_PWR         8'h07

// Field positions
`define SSD_SRC_DIRECT_BIT  2
`define SSD_FB_LOOP2_BIT    4
`define SSD_FB_LOOP1_BIT    3
`define SSD_FB_SEL_HI       2
`define SSD_FB_SEL_LO       1
`define SSD_FB_EN_BIT       0
`define SSD_PWR_SYSREF_BIT  2
`define SSD_PWR_PLSR_BIT    0

// Source codes
`define SSD_SRC_SYNC        2'h0
`define SSD_SRC_RECLK       2'h1
`define SSD_SRC_BURST       2'h2
`define SSD_SRC_CONT        2'h3

// Serial frame: R/W, two spare bits, 13-bit address, 8 data bits
`define SSD_FRAME_BITS      5'h18
`define SSD_HDR_BITS        5'h10

`endif

// File: rtl/ssd_sync2.v
// Purpose: Two flip-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to core_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module ssd_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    // Double register to settle metastability
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // ssd_sync2

// File: test/ssd_sysref_ctrl_properties.sv
// Purpose: Port-level checks for the SYSREF control block
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Register-driven outputs may only move after a finished frame
`timescale 1ns/1ps
module ssd_sysref_ctrl_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdo_oe,
    input wire logic feedback_clk_out,
    input wire logic loop_two_ndiv_input_select,
    input wire logic loop_one_ndelay_input_select,
    input wire logic feedback_select_power_on,
    input wire logic sysref_burst_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Feedback power-on off for two samples, port idle long enough
    sequence s_fb_off;
        !feedback_select_power_on [*2];
    endsequence
    sequence s_cs_idle;
        spi_cs_n [*5];
    endsequence

    property p_fb_gate;
        s_fb_off |-> !feedback_clk_out;
    endproperty
    a_fb_gate: assert property (p_fb_gate) else $error("feedback out while off");
    // Register bits only change once the frame select is back high
    property p_loop2_quiet;
        $changed(loop_two_ndiv_input_select) |-> $past(spi_cs_n, 1) && $past(spi_cs_n, 2);
    endproperty
    a_loop2_quiet: assert property (p_loop2_quiet) else $error("loop two select moved");
    property p_loop1_quiet;
        $changed(loop_one_ndelay_input_select) |-> $past(spi_cs_n, 1) && $past(spi_cs_n, 2);
    endproperty
    a_loop1_quiet: assert property (p_loop1_quiet) else $error("loop one select moved");
    property p_pwr_quiet;
        $changed(feedback_select_power_on) |-> $past(spi_cs_n, 1) && $past(spi_cs_n, 2);
    endproperty
    a_pwr_quiet: assert property (p_pwr_quiet) else $error("power-on bit moved");
    property p_oe_start;
        $rose(spi_sdo_oe) |-> !spi_cs_n && !$past(spi_sck, 1);
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("read drive outside frame");
    property p_oe_idle;
        s_cs_idle |-> !spi_sdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("read drive while idle");
    property p_busy_cause;
        $rose(sysref_burst_busy) |-> $past(spi_cs_n, 1) && $past(spi_cs_n, 2);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("burst without write");
    property p_busy_min;
        $rose(sysref_burst_busy) |-> sysref_burst_busy [*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("burst too short");
endmodule // ssd_sysref_ctrl_properties

bind ssd_sysref_ctrl ssd_sysref_ctrl_properties ssd_sysref_ctrl_properties_i (
    .core_clk, .rst, .spi_sck, .spi_cs_n, .spi_sdo_oe, .feedback_clk_out,
    .loop_two_ndiv_input_select, .loop_one_ndelay_input_select,
    .feedback_select_power_on, .sysref_burst_busy);

// File: test/ssd_converter_model.sv
// Purpose: Converter side that receives SYSREF and times its pulses
// Assumes: SYSREF sampled on the distribution clock
// Notes:   Period and high time are those of the latest pulse
`timescale 1ns/1ps
module ssd_converter_model (
    input  wire logic core_clk,
    input  wire logic sysref_in,
    input  wire logic clear,
    output int        edges,
    output int        period,
    output int        high_len
);
    logic last;
    int   since;
    // Count rising edges, as frame alignment would
    always @(posedge core_clk) begin
        last <= sysref_in;
        since <= since + 1;
        if (clear) edges <= 0;
        else if (sysref_in && !last) begin
            edges <= edges + 1;
            period <= since;
            since <= 1;
        end
        if (!sysref_in && last) high_len <= since;
    end
endmodule // ssd_converter_model

// File: test/sysref_source_divider_feedback_cfg_test.sv
// Purpose: Register, mode, divider and burst tests over the serial port
// Assumes: Serial clock phases of six core cycles
// Notes:   Delay checked by the shift of the first pulse after a sync
`timescale 1ns/1ps
module sysref_source_divider_feedback_cfg_test;
    logic core_clk = 0, rst = 1, spi_sck = 0, spi_cs_n = 1, spi_sdi = 0, sync_in = 0;
    logic reference_input_zero = 0, device_clock_output_six = 1, device_clock_output_eight = 0;
    logic external_feedback_in = 1, clr = 0, oe_seen;
    logic spi_sdo, spi_sdo_oe, sysref_out, feedback_clk_out, sysref_burst_busy;
    logic loop_two_ndiv_input_select, loop_one_ndelay_input_select, feedback_select_power_on;
    int   failures = 0, tests_run = 0, cycles = 0, edges, period, high_len;
    logic [7:0] rst_tab [9] = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h08, 8'h03, 8'h00, 8'h07, 8'h00};
    logic [7:0] msk_tab [9] = '{8'h07, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'h03, 8'h1f, 8'h07, 8'h00};
    logic [7:0] mode_tab [3] = '{8'h00, 8'h01, 8'h04};

    ssd_sysref_ctrl ssd_sysref_ctrl_i (.core_clk, .rst, .spi_sck, .spi_cs_n, .spi_sdi,
        .spi_sdo, .spi_sdo_oe, .sync_in, .reference_input_zero, .device_clock_output_six,
        .device_clock_output_eight, .external_feedback_in, .sysref_out, .feedback_clk_out,
        .loop_two_ndiv_input_select, .loop_one_ndelay_input_select,
        .feedback_select_power_on, .sysref_burst_busy);
    ssd_converter_model ssd_converter_model_i (.core_clk, .sysref_in(sysref_out),
        .clear(clr), .edges, .period, .high_len);

    // 50 MHz clock and a hang limit
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            conclude();
        end
    end

    task tick(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task chk(string what, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One 24-bit frame, MSB first; read bits taken before each rise
    task spi(logic rd, logic [12:0] a, logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 2'b00, a, d};
        spi_cs_n <= 0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi <= f[i];
            spi_sck <= 0;
            tick(6);
            if (i < 8) q[i] = spi_sdo;
            if (i < 8 && rd) oe_seen = oe_seen & spi_sdo_oe;
            spi_sck <= 1;
            tick(6);
        end
        spi_sck <= 0;
        tick(6);
        spi_cs_n <= 1;
        tick(8);
    endtask
    task wr(logic [12:0] a, logic [7:0] d);
        logic [7:0] q;
        spi(1'b0, a, d, q);
    endtask
    task rdc(string n, logic [12:0] a, logic [7:0] e);
        logic [7:0] q;
        oe_seen = 1'b1;
        spi(1'b1, a, 8'h00, q);
        chk(n, e, q);
        chk("sdo_oe", 8'h01, {7'h0, oe_seen});
    endtask
    task clear_count;
        clr <= 1;
        tick(1);
        clr <= 0;
        tick(1);
    endtask
    task conclude;
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        int n, m;
        tick(8);
        rst <= 0;
        tick(4);
        for (int k = 0; k < 9; k++) rdc("reset", 13'h139 + 13'(k), rst_tab[k]);
        for (int k = 0; k < 9; k++) wr(13'h139 + 13'(k), 8'hff);
        chk("burst_in_cont", 8'h00, {7'h0, sysref_burst_busy});
        for (int k = 0; k < 9; k++) rdc("rsvd", 13'h139 + 13'(k), msk_tab[k]);
        chk("loops", 8'h07, {5'h0, loop_two_ndiv_input_select,
            loop_one_ndelay_input_select, feedback_select_power_on});
        for (int s = 0; s < 4; s++) begin
            if (s == 2) continue;
            wr(13'h13f, 8'(2 * s + 1));
            tick(6);
            chk("feedback_path_control", {7'h0, s != 1}, {7'h0, feedback_clk_out});
        end
        wr(13'h13f, 8'h06);
        chk("fb_off", 8'h00, {7'h0, feedback_clk_out});
        // Divide by eleven, minimum delay, then a sync event
        wr(13'h13a, 8'h00);
        wr(13'h13b, 8'h0b);
        wr(13'h13c, 8'h00);
        wr(13'h13d, 8'h08);
        wr(13'h140, 8'h00);
        wr(13'h139, 8'h03);
        sync_in <= 1;
        tick(8);
        sync_in <= 0;
        tick(80);
        chk("period", 8'd11, 8'(period));
        chk("high", 8'd5, 8'(high_len));
        wr(13'h13e, 8'h03);
        chk("burst_in_cont", 8'h00, {7'h0, sysref_burst_busy});
        // Digital delay: first pulse after sync moves by the change in delay
        for (int d = 20; d >= 8; d -= 12) begin
            wr(13'h13d, 8'(d));
            sync_in <= 1;
            tick(5);
            n = 0;
            while (sysref_out !== 1'b1 && n < 100) begin
                tick(1);
                n++;
            end
            sync_in <= 0;
            if (d == 20) m = n;
        end
        chk("delay_step", 8'd12, 8'(m - n));
        // Sync, re-clocked and direct sources; the unused input is opposite, sync held low in direct mode
        foreach (mode_tab[k]) begin
            wr(13'h139, mode_tab[k]);
            for (int v = 1; v >= 0; v--) begin
                sync_in <= v[0] & ~mode_tab[k][2];
                reference_input_zero <= v[0] ^ ~mode_tab[k][2];
                tick(40);
                chk("mode", 8'(v), {7'h0, sysref_out});
            end
        end
        reference_input_zero <= 0;
        wr(13'h140, 8'h04);
        wr(13'h139, 8'h03);
        clear_count();
        tick(100);
        chk("powered_down", 8'h00, 8'(edges));
        // Bursts of every length
        wr(13'h140, 8'h00);
        wr(13'h139, 8'h02);
        tick(30);
        for (int len = 0; len < 4; len++) begin
            clear_count();
            wr(13'h13e, 8'(len));
            chk("busy", 8'h01, {7'h0, sysref_burst_busy});
            n = 0;
            while (sysref_burst_busy !== 1'b0 && n < 600) begin
                tick(1);
                n++;
            end
            tick(30);
            chk("pulses", 8'(1 << len), 8'(edges));
        end
        wr(13'h140, 8'h01);
        clear_count();
        wr(13'h13e, 8'h03);
        tick(150);
        chk("gen_off", 8'h00, 8'(edges));
        // Feedback from the divider: high for half of an eleven-cycle period
        wr(13'h13f, 8'h05);
        n = 0;
        repeat (11) begin
            tick(1);
            if (feedback_clk_out === 1'b1) n++;
        end
        chk("fb_divider", 8'd5, 8'(n));
        conclude();
    end
endmodule // sysref_source_divider_feedback_cfg_test
